// ---- include/run_setpoint_pkg.sv ----
// constants shared by the three-wire run command and setpoint front-end
// assumes mclk at 20 MHz and settings held stable by the parameter store
package run_setpoint_pkg;
    // ************************************************************
    // clock and tick timing
    // ************************************************************
    localparam int          CLK_PERIOD_NS   = 50;
    localparam int          TICK_TIME_US    = 1000;
    localparam int          TICK_CYCLES     = (TICK_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                                              / CLK_PERIOD_NS;
    localparam int          TICKS_PER_10MS  = 10;
    // ************************************************************
    // setting codes
    // ************************************************************
    localparam logic [3:0]  MODE_THREE_ONE  = 4'h2;
    localparam logic [3:0]  MODE_THREE_TWO  = 4'h3;
    localparam logic [3:0]  SOURCE_TERMINAL = 4'h1;
    localparam logic [5:0]  FUNC_FORWARD    = 6'h01;
    localparam logic [5:0]  FUNC_REVERSE    = 6'h02;
    localparam logic [5:0]  FUNC_PERMIT     = 6'h03;
    // ************************************************************
    // up/down rate, units of 0.001 Hz/s
    // ************************************************************
    localparam logic [15:0] RATE_DEFAULT    = 16'h03e8;
    localparam logic [31:0] UHZ_PER_LSB     = 32'h0000_2710;
    // ************************************************************
    // analog curves, volts in 0.01 V, percent in 0.1 %
    // ************************************************************
    localparam logic [9:0]         VOLT_MAX        = 10'h3e8;
    localparam logic [9:0]         CURVE_MIN_IN_DEF = 10'h000;
    localparam logic [9:0]         CURVE_MAX_IN_DEF = 10'h3e8;
    localparam logic signed [11:0] PCT_MIN_DEF     = 12'sh000;
    localparam logic signed [11:0] PCT_MAX_DEF     = 12'sh3e8;
    localparam logic signed [11:0] PCT_LOW_LIMIT   = -12'sh3e8;
    localparam logic signed [11:0] PCT_MIN_HIGH    = 12'sh3e8;
    localparam logic signed [11:0] PCT_MAX_HIGH    = 12'sh5dc;
    localparam logic signed [31:0] PCT_FULL        = 32'sh0000_03e8;
    // filter time, units of 0.01 s
    localparam logic [9:0]  FILTER_DEFAULT  = 10'h00a;
    localparam logic [9:0]  FILTER_LIMIT    = 10'h3e8;
    localparam int          FRAC_BITS       = 16;
    // ************************************************************
    // run state
    // ************************************************************
    typedef enum logic [2:0] {
        RUN_STOP    = 3'b001,
        RUN_FORWARD = 3'b010,
        RUN_REVERSE = 3'b100
    } run_state_t;
endpackage

// ---- core/three_wire_run_command_setpoint.sv ----
// three-wire terminal run decoding, up/down frequency ramp and two analog curves
// assumes terminal pins are asynchronous and analog words come from an adc on mclk
//
// Behaviour
// - mode one: third permits, first forward, second reverse
// - permit opening stops at once
// - mode one acts on closing edges, three cycles after the pin closes
// - mode one latches last action of three
// - mode two: first runs, second direction, third permits
// - mode two: direction open forward, closed reverse
// - mode two starts on run closing edge
// - mode setting 2 is one, 3 two
// - terminals govern only with source setting 1
// - function codes 1 forward, 2 reverse, 3 permit
// - up/down ramps at programmable hertz per second
// - curve one maps end points linearly
// - end point percentages clamped to their ranges
// - percentage scaled against maximum output frequency
// - analog input one smoothed by filter time
// - curve two behaves like curve one
`timescale 1ns/10ps
module three_wire_run_command_setpoint #(
    parameter int TICK_CYCLES_P = run_setpoint_pkg::TICK_CYCLES
) (
    // clock, reset, enable
    input  wire logic                mclk,
    input  wire logic                rst_n,
    input  wire logic                clk_en,
    // terminal pins, closed is high
    input  wire logic                input_terminal_one,
    input  wire logic                input_terminal_two,
    input  wire logic                input_terminal_three,
    input  wire logic                up_terminal,
    input  wire logic                down_terminal,
    // run settings
    input  wire logic [3:0]          terminal_mode_setting,
    input  wire logic [3:0]          run_source_setting,
    input  wire logic [5:0]          terminal_one_function,
    input  wire logic [5:0]          terminal_two_function,
    input  wire logic [5:0]          terminal_three_function,
    // frequency settings, 0.01 Hz and 0.001 Hz/s
    input  wire logic [15:0]         max_output_frequency,
    input  wire logic [15:0]         updown_rate_setting,
    // analog words, 0.01 V
    input  wire logic [9:0]          analog_input_one,
    input  wire logic [9:0]          analog_input_two,
    // curve settings
    input  wire logic [9:0]          curve_one_min_input,
    input  wire logic [9:0]          curve_one_max_input,
    input  wire logic signed [11:0]  curve_one_min_percent,
    input  wire logic signed [11:0]  curve_one_max_percent,
    input  wire logic [9:0]          curve_two_min_input,
    input  wire logic [9:0]          curve_two_max_input,
    input  wire logic signed [11:0]  curve_two_min_percent,
    input  wire logic signed [11:0]  curve_two_max_percent,
    input  wire logic [9:0]          analog_one_filter_time,
    // run commands
    output logic                     run_command,
    output logic                     forward_command,
    output logic                     reverse_command,
    output logic                     terminal_control_active,
    // setpoints
    output logic [15:0]              updown_frequency,
    output logic [9:0]               analog_one_filtered,
    output logic signed [11:0]       curve_one_percent,
    output logic signed [11:0]       curve_two_percent,
    output logic signed [17:0]       curve_one_frequency,
    output logic signed [17:0]       curve_two_frequency
);
    import run_setpoint_pkg::*;

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic signed [11:0] clamp_pct(input logic signed [11:0] v,
                                                     input logic signed [11:0] hi);
        clamp_pct = v;
        if (v < PCT_LOW_LIMIT) begin
            clamp_pct = PCT_LOW_LIMIT;
        end else if (v > hi) begin
            clamp_pct = hi;
        end
    endfunction

    function automatic logic signed [11:0] curve_map(input logic [9:0]         x,
                                                     input logic [9:0]         min_in,
                                                     input logic [9:0]         max_in,
                                                     input logic signed [11:0] min_pct,
                                                     input logic signed [11:0] max_pct);
        logic [9:0]         lo;
        logic [9:0]         hi;
        logic signed [11:0] pl;
        logic signed [11:0] ph;
        logic signed [31:0] num;
        logic signed [31:0] span;

        lo   = min_in;
        hi   = (max_in > VOLT_MAX) ? VOLT_MAX : max_in;
        if (lo > hi) begin
            lo = hi;
        end
        pl   = clamp_pct(min_pct, PCT_MIN_HIGH);
        ph   = clamp_pct(max_pct, PCT_MAX_HIGH);
        num  = 32'($signed({22'h0, x - lo})) * (32'(ph) - 32'(pl));
        span = $signed({22'h0, hi - lo});
        if (x <= lo) begin
            curve_map = pl;
        end else if (x >= hi) begin
            curve_map = ph;
        end else begin
            curve_map = 12'(32'(pl) + num / span);
        end
    endfunction

    // floor log2 of the time constant in ticks; a power-of-two step trades exact
    // time constant for a divider-free filter
    function automatic logic [4:0] filter_shift(input logic [9:0] t);
        logic [17:0] ticks;

        filter_shift = 5'h00;
        ticks        = 18'(t > FILTER_LIMIT ? FILTER_LIMIT : t) * 18'(TICKS_PER_10MS);
        for (int i = 0; i < 18; i++) begin
            if (ticks[i]) begin
                filter_shift = 5'(i);
            end
        end
    endfunction

    function automatic logic signed [17:0] pct_to_freq(input logic signed [11:0] p,
                                                       input logic [15:0]        fmax);
        logic signed [31:0] prod;

        prod        = 32'(p) * $signed({16'h0, fmax});
        pct_to_freq = 18'(prod / PCT_FULL);
    endfunction

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [4:0] pin_meta_reg;
    logic [4:0] pin_sync_reg;
    logic [4:0] pin_prev_reg;
    // first flop may be metastable, never read by logic

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_reg <= 5'h00;
            pin_sync_reg <= 5'h00;
            pin_prev_reg <= 5'h00;
        end else if (clk_en) begin
            pin_meta_reg <= {down_terminal, up_terminal, input_terminal_three,
                             input_terminal_two, input_terminal_one};
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    logic t_one;
    logic t_two;
    logic t_permit;
    logic rise_one;
    logic rise_two;

    assign t_one    = pin_sync_reg[0];
    assign t_two    = pin_sync_reg[1];
    assign t_permit = pin_sync_reg[2];
    assign rise_one = pin_sync_reg[0] & ~pin_prev_reg[0];
    assign rise_two = pin_sync_reg[1] & ~pin_prev_reg[1];

    // ************************************************************
    // run command decoding
    // ************************************************************
    logic mode_one;
    logic mode_two;
    logic codes_ok;
    logic active;

    assign mode_one = (terminal_mode_setting == MODE_THREE_ONE);
    assign mode_two = (terminal_mode_setting == MODE_THREE_TWO);
    assign codes_ok = (terminal_one_function == FUNC_FORWARD)
                    & (terminal_two_function == FUNC_REVERSE)
                    & (terminal_three_function == FUNC_PERMIT);
    assign active   = (run_source_setting == SOURCE_TERMINAL) & codes_ok
                    & (mode_one | mode_two);

    run_state_t run_reg;
    run_state_t run_next;

    // permit open or terminal control inactive forces a stop from any state
    always_comb begin
        run_next = run_reg;
        case (run_reg)
            RUN_STOP: begin
                if (mode_one && t_permit && rise_one) begin
                    run_next = RUN_FORWARD;
                end else if (mode_one && t_permit && rise_two) begin
                    run_next = RUN_REVERSE;
                end else if (mode_two && t_permit && rise_one) begin
                    run_next = t_two ? RUN_REVERSE : RUN_FORWARD;
                end
            end
            RUN_FORWARD, RUN_REVERSE: begin
                if (mode_one && rise_one) begin
                    run_next = RUN_FORWARD;
                end else if (mode_one && rise_two) begin
                    run_next = RUN_REVERSE;
                end else if (mode_two) begin
                    run_next = t_two ? RUN_REVERSE : RUN_FORWARD;
                end
            end
            default: begin
                run_next = RUN_STOP;
            end
        endcase
        if (!active || !t_permit) begin
            run_next = RUN_STOP;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            run_reg <= RUN_STOP;
        end else if (clk_en) begin
            run_reg <= run_next;
        end
    end

    assign run_command             = (run_reg != RUN_STOP);
    assign forward_command         = (run_reg == RUN_FORWARD);
    assign reverse_command         = (run_reg == RUN_REVERSE);
    assign terminal_control_active = active;

    // ************************************************************
    // tick
    // ************************************************************
    // one tick paces the ramp and the filter
    localparam int TW = $clog2(TICK_CYCLES_P + 1);
    logic [TW-1:0] tick_cnt_reg;
    logic          tick;

    assign tick = (tick_cnt_reg == TW'(TICK_CYCLES_P - 1));

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_reg <= '0;
        end else if (clk_en) begin
            tick_cnt_reg <= tick ? '0 : tick_cnt_reg + TW'(1);
        end
    end

    // ************************************************************
    // up/down ramp, held in micro-hertz
    // ************************************************************
    logic [31:0] ud_uhz_reg;
    logic [31:0] ud_limit;
    logic [31:0] ud_step;
    logic [32:0] ud_sum;
    logic        go_up;
    logic        go_down;

    assign ud_limit = 32'(max_output_frequency) * UHZ_PER_LSB;
    assign ud_step  = {16'h0, updown_rate_setting};
    assign ud_sum   = {1'b0, ud_uhz_reg} + {1'b0, ud_step};
    // up and down together cancel
    assign go_up    = pin_sync_reg[3] & ~pin_sync_reg[4];
    assign go_down  = pin_sync_reg[4] & ~pin_sync_reg[3];

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ud_uhz_reg <= 32'h0;
        end else if (clk_en) begin
            if (ud_uhz_reg > ud_limit) begin
                ud_uhz_reg <= ud_limit;
            end else if (tick && go_up) begin
                ud_uhz_reg <= (ud_sum > {1'b0, ud_limit}) ? ud_limit : ud_sum[31:0];
            end else if (tick && go_down) begin
                ud_uhz_reg <= (ud_uhz_reg > ud_step) ? ud_uhz_reg - ud_step : 32'h0;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            updown_frequency <= 16'h0;
        end else if (clk_en) begin
            updown_frequency <= 16'(ud_uhz_reg / UHZ_PER_LSB);
        end
    end

    // ************************************************************
    // analog input one filter
    // ************************************************************
    logic [9+FRAC_BITS:0]          filt_reg;
    logic signed [10+FRAC_BITS:0]  filt_diff;
    logic [4:0]                    filt_k;

    assign filt_k    = filter_shift(analog_one_filter_time);
    assign filt_diff = $signed({1'b0, analog_input_one, 16'h0}) - $signed({1'b0, filt_reg});

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            filt_reg <= '0;
        end else if (clk_en && tick) begin
            filt_reg <= 26'($signed({1'b0, filt_reg}) + (filt_diff >>> filt_k));
        end
    end

    assign analog_one_filtered = filt_reg[9+FRAC_BITS:FRAC_BITS];

    // ************************************************************
    // curves and frequency scaling
    // ************************************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            curve_one_percent <= 12'sh000;
            curve_two_percent <= 12'sh000;
        end else if (clk_en) begin
            curve_one_percent <= curve_map(analog_one_filtered, curve_one_min_input,
                                           curve_one_max_input, curve_one_min_percent,
                                           curve_one_max_percent);
            // input two has no filter
            curve_two_percent <= curve_map(analog_input_two, curve_two_min_input,
                                           curve_two_max_input, curve_two_min_percent,
                                           curve_two_max_percent);
        end
    end

    // one cycle behind the percentages so the wide multiply sits in its own stage
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            curve_one_frequency <= 18'sh00000;
            curve_two_frequency <= 18'sh00000;
        end else if (clk_en) begin
            curve_one_frequency <= pct_to_freq(curve_one_percent, max_output_frequency);
            curve_two_frequency <= pct_to_freq(curve_two_percent, max_output_frequency);
        end
    end
endmodule

// ---- tb/three_wire_run_command_setpoint_assertions.sv ----
// concurrent checks on the run decode of the terminal front-end
// assumes settings only change while the drive is stopped
`timescale 1ns/10ps
module run_setpoint_checker
    import run_setpoint_pkg::*;
(
    // clock and reset
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       clk_en,
    // terminals and settings
    input wire logic       input_terminal_one,
    input wire logic       input_terminal_two,
    input wire logic       input_terminal_three,
    input wire logic [3:0] terminal_mode_setting,
    input wire logic [3:0] run_source_setting,
    input wire logic [5:0] terminal_one_function,
    input wire logic [5:0] terminal_two_function,
    input wire logic [5:0] terminal_three_function,
    // run commands
    input wire logic       run_command,
    input wire logic       forward_command,
    input wire logic       reverse_command,
    input wire logic       terminal_control_active
);
    logic mode_one;
    logic mode_two;
    assign mode_one = terminal_mode_setting == MODE_THREE_ONE;
    assign mode_two = terminal_mode_setting == MODE_THREE_TWO;
    default clocking @(posedge mclk); endclocking
    // a frozen clock enable stretches every latency, so it aborts the checks
    default disable iff (!rst_n || !clk_en);
    sequence s_held;
        (terminal_control_active && input_terminal_three) [*3];
    endsequence
    property p_decode;
        terminal_control_active == (run_source_setting == SOURCE_TERMINAL
            && (mode_one || mode_two) && terminal_one_function == FUNC_FORWARD
            && terminal_two_function == FUNC_REVERSE && terminal_three_function == FUNC_PERMIT);
    endproperty
    property p_inactive;
        !terminal_control_active |=> !run_command;
    endproperty
    property p_onehot;
        run_command == (forward_command || reverse_command) && !(forward_command && reverse_command);
    endproperty
    property p_permit_stop;
        $fell(input_terminal_three) |-> ##3 !run_command;
    endproperty
    property p_fwd_press;
        (mode_one && $rose(input_terminal_one)) ##0 s_held |-> ##1 forward_command;
    endproperty
    property p_two_start;
        (mode_two && $rose(input_terminal_one)) ##0 s_held |-> ##1 run_command;
    endproperty
    property p_closing_edge;
        $rose(run_command) |-> ($past(input_terminal_one, 3) && !$past(input_terminal_one, 4))
            || (mode_one && $past(input_terminal_two, 3) && !$past(input_terminal_two, 4));
    endproperty
    property p_direction;
        mode_two && run_command && $past(run_command)
            |-> reverse_command == $past(input_terminal_two, 3);
    endproperty
    a_decode: assert property (p_decode) else $error("terminal control decode wrong");
    a_inactive: assert property (p_inactive) else $error("run while inactive");
    a_onehot: assert property (p_onehot) else $error("direction not one-hot");
    a_permit_stop: assert property (p_permit_stop) else $error("permit open kept run");
    a_fwd_press: assert property (p_fwd_press) else $error("forward press ignored");
    a_two_start: assert property (p_two_start) else $error("mode two start missed");
    a_closing_edge: assert property (p_closing_edge) else $error("start without edge");
    a_direction: assert property (p_direction) else $error("mode two direction wrong");
endmodule
bind three_wire_run_command_setpoint run_setpoint_checker u_checker (
    .mclk, .rst_n, .clk_en, .input_terminal_one, .input_terminal_two, .input_terminal_three,
    .terminal_mode_setting, .run_source_setting, .terminal_one_function,
    .terminal_two_function, .terminal_three_function, .run_command, .forward_command,
    .reverse_command, .terminal_control_active);

// ---- tb/operator_panel.sv ----
// operator buttons and switch on the three run terminals
// assumes the bench calls its tasks; pins change just after a rising edge
`timescale 1ns/10ps
module operator_panel (
    // clock
    input wire logic mclk,
    // terminal pins, closed is high
    output logic     input_terminal_one,
    output logic     input_terminal_two,
    output logic     input_terminal_three
);
    initial begin
        input_terminal_one = 1'b0;
        input_terminal_two = 1'b0;
        input_terminal_three = 1'b0;
    end
    task automatic set_pin(input int which, input logic level);
        @(posedge mclk);
        case (which)
            1: input_terminal_one <= level;
            2: input_terminal_two <= level;
            default: input_terminal_three <= level;
        endcase
    endtask
    // momentary press, held three edges so the sync chain sees it
    task automatic press(input int which);
        set_pin(which, 1'b1);
        repeat (2) @(posedge mclk);
        set_pin(which, 1'b0);
    endtask
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the three-wire run and setpoint front-end
// assumes the panel model drives the run terminals, tick shortened to 8
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("wrong value %s expected %0d seen %0d", nm, exp, got); end end
module testbench;
    import run_setpoint_pkg::*;
    localparam int TICK = 8;
    logic mclk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, up_terminal = 1'b0, down_terminal = 1'b0;
    wire input_terminal_one, input_terminal_two, input_terminal_three;
    logic [3:0] terminal_mode_setting = MODE_THREE_ONE, run_source_setting = SOURCE_TERMINAL;
    logic [5:0] terminal_one_function = FUNC_FORWARD, terminal_two_function = FUNC_REVERSE;
    logic [5:0] terminal_three_function = FUNC_PERMIT;
    logic [15:0] max_output_frequency = 16'h0014, updown_rate_setting = 16'h2710;
    logic [9:0] analog_input_one = 10'h000, analog_input_two = 10'h000;
    logic [9:0] curve_one_min_input = 10'h064, curve_one_max_input = 10'h384;
    logic [9:0] curve_two_min_input = CURVE_MIN_IN_DEF, curve_two_max_input = CURVE_MAX_IN_DEF;
    logic signed [11:0] curve_one_min_percent = -12'sh0c8, curve_one_max_percent = 12'sh258;
    logic signed [11:0] curve_two_min_percent = PCT_MIN_DEF, curve_two_max_percent = PCT_MAX_DEF;
    logic [9:0] analog_one_filter_time = 10'h000;
    logic run_command, forward_command, reverse_command, terminal_control_active;
    logic [15:0] updown_frequency;
    logic [9:0] analog_one_filtered;
    logic signed [11:0] curve_one_percent, curve_two_percent;
    logic signed [17:0] curve_one_frequency, curve_two_frequency;
    int n_tests = 0, n_mismatch = 0, cycles = 0;
    logic [9:0] ax [3] = '{10'h032, 10'h1f4, 10'h3b6};
    logic signed [11:0] p1 [3] = '{-12'sh0c8, 12'sh0c8, 12'sh258};
    logic signed [17:0] f1 [3] = '{-18'sh00004, 18'sh00004, 18'sh0000c};
    logic signed [17:0] f2 [3] = '{18'sh00001, 18'sh0000a, 18'sh00013};
    three_wire_run_command_setpoint #(.TICK_CYCLES_P(TICK)) dut (
        .mclk, .rst_n, .clk_en, .input_terminal_one, .input_terminal_two, .input_terminal_three,
        .up_terminal, .down_terminal, .terminal_mode_setting, .run_source_setting,
        .terminal_one_function, .terminal_two_function, .terminal_three_function,
        .max_output_frequency, .updown_rate_setting, .analog_input_one, .analog_input_two,
        .curve_one_min_input, .curve_one_max_input, .curve_one_min_percent,
        .curve_one_max_percent, .curve_two_min_input, .curve_two_max_input,
        .curve_two_min_percent, .curve_two_max_percent, .analog_one_filter_time,
        .run_command, .forward_command, .reverse_command, .terminal_control_active,
        .updown_frequency, .analog_one_filtered, .curve_one_percent, .curve_two_percent,
        .curve_one_frequency, .curve_two_frequency);
    operator_panel panel (.mclk, .input_terminal_one, .input_terminal_two, .input_terminal_three);
    always #25 mclk = ~mclk;
    // ****
    // tasks
    // ****
    task automatic test_done;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // checks land mid-cycle, clear of the launching edge
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            test_done;
        end
    end
    // ****
    // scenarios
    // ****
    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        settle(1);
        `CHK("active", 1'b1, terminal_control_active)
        panel.set_pin(3, 1'b1);
        panel.press(1);
        settle(4);
        `CHK("fwd run", 1'b1, run_command)
        `CHK("fwd", 1'b1, forward_command)
        settle(4);
        `CHK("fwd latched", 1'b1, forward_command)
        panel.press(2);
        settle(4);
        `CHK("rev", 1'b1, reverse_command)
        panel.set_pin(3, 1'b0);
        settle(4);
        `CHK("permit stop", 1'b0, run_command)
        panel.press(1);
        panel.set_pin(3, 1'b1);
        settle(6);
        `CHK("no late start", 1'b0, run_command)
        panel.set_pin(3, 1'b0);
        @(posedge mclk) terminal_mode_setting <= MODE_THREE_TWO;
        panel.set_pin(1, 1'b1);
        panel.set_pin(3, 1'b1);
        settle(6);
        `CHK("level no start", 1'b0, run_command)
        panel.set_pin(1, 1'b0);
        panel.press(1);
        settle(4);
        `CHK("two run", 1'b1, run_command)
        `CHK("two fwd", 1'b1, forward_command)
        panel.set_pin(2, 1'b1);
        settle(4);
        `CHK("two rev", 1'b1, reverse_command)
        @(posedge mclk) run_source_setting <= 4'h0;
        settle(2);
        `CHK("source off", 1'b0, run_command)
        @(posedge mclk) run_source_setting <= SOURCE_TERMINAL;
        terminal_mode_setting <= 4'h4;
        settle(1);
        `CHK("mode other", 1'b0, terminal_control_active)
        @(posedge mclk) terminal_mode_setting <= MODE_THREE_ONE;
        terminal_three_function <= 6'h04;
        settle(1);
        `CHK("bad function", 1'b0, terminal_control_active)
        // up/down: rate 10000 gives one 0.01 Hz step each tick
        @(posedge mclk) up_terminal <= 1'b1;
        repeat (10 * TICK) @(posedge mclk);
        up_terminal <= 1'b0;
        settle(2);
        `CHK("ramp", 1'b1, updown_frequency >= 16'h0009 && updown_frequency <= 16'h000b)
        @(posedge mclk) up_terminal <= 1'b1;
        settle(20 * TICK);
        `CHK("ramp top", max_output_frequency, updown_frequency)
        @(posedge mclk) down_terminal <= 1'b1;
        settle(10 * TICK);
        `CHK("both held", max_output_frequency, updown_frequency)
        @(posedge mclk) clk_en <= 1'b0;
        up_terminal <= 1'b0;
        settle(10 * TICK);
        `CHK("frozen", max_output_frequency, updown_frequency)
        @(posedge mclk) up_terminal <= 1'b0;
        clk_en <= 1'b1;
        updown_rate_setting <= 16'hffff;
        settle(10 * TICK);
        `CHK("ramp floor", 16'h0000, updown_frequency)
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk) analog_input_one <= ax[i];
            analog_input_two <= ax[i];
            settle(5 * TICK);
            `CHK("filtered", ax[i], analog_one_filtered)
            `CHK("curve one", p1[i], curve_one_percent)
            `CHK("curve two", $signed({2'b00, ax[i]}), curve_two_percent)
            `CHK("curve freq", f1[i], curve_one_frequency)
            `CHK("curve two freq", f2[i], curve_two_frequency)
        end
        @(posedge mclk) curve_one_min_input <= 10'h258;
        curve_one_max_input <= 10'h190;
        curve_one_min_percent <= -12'sh5dc;
        curve_one_max_percent <= 12'sh640;
        analog_input_one <= 10'h1f4;
        settle(5 * TICK);
        `CHK("swapped points", 12'sh5dc, curve_one_percent)
        @(posedge mclk) analog_input_one <= 10'h12c;
        settle(5 * TICK);
        `CHK("low clamp", -12'sh3e8, curve_one_percent)
        // longer filter time: a step must arrive only gradually
        @(posedge mclk) analog_one_filter_time <= FILTER_DEFAULT;
        analog_input_one <= 10'h3e8;
        settle(2 * TICK);
        `CHK("slow filter", 1'b1, analog_one_filtered > 10'h12c && analog_one_filtered < 10'h3e8)
        test_done;
    end
endmodule
